// ### src/hsc_config_crc.sv
// configuration decode and checksummed register read stream of the hall sensor
// How it works
// - operating state code 0h decodes as standby, no continuous conversion.
// - trigger code 0h means conversion started by bus; it is the reset value.
// - axis channel code 3h enables the X and Y channels.
// - one range bit serves X and Y; Z range is a separate writable bit.
// - low range variant: planar range 1h selects 80 mT full scale.
// - high range variant: 0h selects 120 mT (default), 1h selects 240 mT.
// - angle select 1h enables angle from X first, Y second.
// - checksum enable 1h turns on checksum generation on reads.
// - read format 0h is the standard read format.
// - checksum byte only sent when enabled and standard format chosen.
// - checksum goes out as fifth byte, right after four data bytes.
// - checksum covers the four bytes just sent, seeded with FFh.
// - only the final checksum is sent, never the per-byte values.
// - each step follows polynomial x^8+x^2+x+1.
// - read returns start address data, next three addresses, then checksum.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_cfg.svh"

module hsc_config_crc #(
   parameter bit HIGH_RANGE = 1'b0,
   parameter int DATA_DEPTH = 16
) (
   input  wire logic                    clock,
   input  wire logic                    sys_rst,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,
   input  wire logic                    stream_start,
   input  wire logic [7:0]              stream_addr,
   input  wire logic                    stream_pop,
   output hsc_pkg::hsc_byte_type        stream_out,
   output hsc_pkg::hsc_cfg_type         cfg_out
);

   localparam int IW = (DATA_DEPTH > 1) ? $clog2(DATA_DEPTH) : 1;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   hsc_pkg::hsc_dev1_type  dev1;
   hsc_pkg::hsc_dev2_type  dev2;
   hsc_pkg::hsc_sen1_type  sen1;
   hsc_pkg::hsc_sen2_type  sen2;
   logic [7:0]             data_mem [DATA_DEPTH];
   hsc_pkg::hsc_state_type state;
   logic [7:0]             ptr;
   logic [7:0]             crc;
   logic [2:0]             sent_count;
   logic                   crc_on;
   logic [7:0]             status;
   logic [7:0]             bus_byte;
   logic [7:0]             stream_byte;
   logic [7:0]             crc_next;
   logic                   data_pop;
   logic                   check_pop;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // config writes land directly; spare bits are kept but unused
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         dev1 <= `HSC_RST_DEV1;
         dev2 <= `HSC_RST_DEV2;
         sen1 <= `HSC_RST_SEN1;
         sen2 <= `HSC_RST_SEN2;
      end else if (reg_wr) begin
         case (reg_addr)
            `HSC_OFF_DEV1: begin
               dev1 <= reg_wdata;
            end
            `HSC_OFF_DEV2: begin
               dev2 <= reg_wdata;
            end
            `HSC_OFF_SEN1: begin
               sen1 <= reg_wdata;
            end
            `HSC_OFF_SEN2: begin
               sen2 <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // data bytes behind the config block, written by software
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < DATA_DEPTH; i++) begin
            data_mem[i] <= `HSC_RST_BYTE;
         end
      end else if (reg_wr && in_data(reg_addr)) begin
         data_mem[data_index(reg_addr)] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // address decode helpers
   // ------------------------------------------------------------
   function automatic logic in_data(input logic [7:0] a);
      logic [7:0] off;
      off = a - `HSC_OFF_DATA;
      return (a >= `HSC_OFF_DATA) && (off < 8'(DATA_DEPTH));
   endfunction

   function automatic logic [IW-1:0] data_index(input logic [7:0] a);
      logic [7:0] off;
      off = a - `HSC_OFF_DATA;
      return off[IW-1:0];
   endfunction

   // one map serves both the bus and the read stream; unmapped reads as zero
   function automatic logic [7:0] map_read(input logic [7:0] a, input logic [39:0] regs, input logic [7:0] mem_byte);
      logic [7:0] r;
      r = `HSC_RST_BYTE;
      case (a)
         `HSC_OFF_DEV1: begin
            r = regs[39:32];
         end
         `HSC_OFF_DEV2: begin
            r = regs[31:24];
         end
         `HSC_OFF_SEN1: begin
            r = regs[23:16];
         end
         `HSC_OFF_SEN2: begin
            r = regs[15:8];
         end
         `HSC_OFF_STAT: begin
            r = regs[7:0];
         end
         default: begin
            if (in_data(a)) begin
               r = mem_byte;
            end
         end
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // configuration decode
   // ------------------------------------------------------------
   always_comb begin
      cfg_out.standby     = dev2.operating_state_select == `HSC_OP_STANDBY;
      cfg_out.bus_trigger = dev2.trigger_source == `HSC_TRIG_BUS;
      cfg_out.x_en        = sen1.axis_channel_select == `HSC_CH_XY;
      cfg_out.y_en        = sen1.axis_channel_select == `HSC_CH_XY;
      cfg_out.z_range     = sen2.z_range;
      cfg_out.angle_en    = sen2.angle_select == `HSC_ANGLE_XY;
      // one range bit for both planar axes, scale picked by variant
      if (HIGH_RANGE) begin
         cfg_out.xy_full_scale_mt = (sen2.xy_range == `HSC_XY_WIDE) ? `HSC_FS_HI_WIDE : `HSC_FS_HI_NARROW;
      end else begin
         cfg_out.xy_full_scale_mt = (sen2.xy_range == `HSC_XY_WIDE) ? `HSC_FS_LO_WIDE : `HSC_FS_LO_NARROW;
      end
   end

   // status: live view of decode and stream
   assign status = {1'b0, crc_on, state, cfg_out.angle_en, cfg_out.y_en, cfg_out.x_en, cfg_out.standby};

   // ------------------------------------------------------------
   // register port read
   // ------------------------------------------------------------
   assign bus_byte    = map_read(reg_addr, {dev1, dev2, sen1, sen2, status}, data_mem[data_index(reg_addr)]);
   assign stream_byte = map_read(ptr, {dev1, dev2, sen1, sen2, status}, data_mem[data_index(ptr)]);

   // read data stand for exactly the cycle after the strobe
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= `HSC_RST_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= bus_byte;
      end else begin
         reg_rdata <= `HSC_RST_BYTE;
      end
   end

   // ------------------------------------------------------------
   // read stream with trailing checksum
   // ------------------------------------------------------------
   hsc_crc_step u_crc (
      .crc_in  (crc),
      .data_in (stream_byte),
      .crc_out (crc_next)
   );

   // a start in the same cycle as a pop wins; that pop is dropped
   assign data_pop  = stream_pop && !stream_start && (state == hsc_pkg::HSC_DATA);
   assign check_pop = stream_pop && !stream_start && (state == hsc_pkg::HSC_CHECK);

   // sequencing: data bytes from consecutive addresses, then the checksum
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= hsc_pkg::HSC_IDLE;
      end else if (stream_start) begin
         state <= hsc_pkg::HSC_DATA;
      end else if (stream_pop) begin
         case (state)
            hsc_pkg::HSC_DATA: begin
               if (crc_on && sent_count == `HSC_LAST_DATA) begin
                  state <= hsc_pkg::HSC_CHECK;
               end
            end
            hsc_pkg::HSC_CHECK: begin
               state <= hsc_pkg::HSC_IDLE;
            end
            default: begin
               state <= hsc_pkg::HSC_IDLE;
            end
         endcase
      end
   end

   // gate is sampled once per read so a mid-read write cannot split a frame
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         crc_on <= 1'b0;
      end else if (stream_start) begin
         crc_on <= (dev1.crc_en == `HSC_CRC_ON) && (dev1.read_format == `HSC_FMT_STD);
      end
   end

   // address walks upward one byte per data pop
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ptr <= `HSC_RST_BYTE;
      end else if (stream_start) begin
         ptr <= stream_addr;
      end else if (data_pop) begin
         ptr <= ptr + 8'h01;
      end
   end

   // checksum chain over the bytes actually sent, saturating count
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         crc        <= `HSC_CRC_SEED;
         sent_count <= 3'h0;
      end else if (stream_start) begin
         crc        <= `HSC_CRC_SEED;
         sent_count <= 3'h0;
      end else if (data_pop) begin
         crc <= crc_next;
         if (sent_count != `HSC_DATA_BYTES) begin
            sent_count <= sent_count + 3'h1;
         end
      end
   end

   // byte out: one cycle after each data or checksum pop; only the final checksum leaves
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stream_out <= '0;
      end else begin
         stream_out.valid  <= data_pop || check_pop;
         stream_out.is_crc <= check_pop;
         if (data_pop) begin
            stream_out.data <= stream_byte;
         end else if (check_pop) begin
            stream_out.data <= crc;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence start_s;
      stream_start;
   endsequence

   sequence data_pop_s;
      stream_pop && !stream_start && state == hsc_pkg::HSC_DATA;
   endsequence

   sequence crc_pop_s;
      stream_pop && !stream_start && state == hsc_pkg::HSC_CHECK;
   endsequence

   standby_decode_a : assert property (cfg_out.standby == (dev2.operating_state_select == 2'h0))
      else $error("standby decode wrong");

   trigger_reset_a : assert property (cfg_out.bus_trigger == (dev2.trigger_source == 2'h0))
      else $error("trigger decode wrong");

   xy_enable_a : assert property ((sen1.axis_channel_select == 4'h3) |-> (cfg_out.x_en && cfg_out.y_en))
      else $error("x and y not enabled for code 3");

   z_independent_a : assert property ((reg_wr && reg_addr == 8'h03) |=> cfg_out.z_range == $past(reg_wdata[1]))
      else $error("z range not written");

   xy_scale_a : assert property (cfg_out.xy_full_scale_mt == (HIGH_RANGE ? (sen2.xy_range ? 8'hF0 : 8'h78)
                                                                         : (sen2.xy_range ? 8'h50 : 8'h28)))
      else $error("planar full scale wrong");

   angle_select_a : assert property (cfg_out.angle_en == (sen2.angle_select == 2'h1))
      else $error("angle enable decode wrong");

   crc_gate_a : assert property (start_s |=> crc_on == ($past(dev1.crc_en) && $past(dev1.read_format) == 2'h0))
      else $error("checksum gate wrong");

   crc_seed_a : assert property (start_s |=> crc == 8'hFF)
      else $error("checksum not seeded");

   data_byte_a : assert property (data_pop_s |=> stream_out.valid && !stream_out.is_crc
                                  && stream_out.data == $past(stream_byte))
      else $error("data byte wrong");

   crc_fifth_a : assert property ((stream_out.valid && stream_out.is_crc) |-> crc_on && sent_count == 3'h4)
      else $error("checksum not fifth");

   crc_final_a : assert property (crc_pop_s |=> stream_out.is_crc && stream_out.data == $past(crc))
      else $error("checksum byte wrong");

   // the count saturates at four, so long frames without checksum keep it there
   crc_chain_a : assert property (data_pop_s |=> crc == $past(crc_next)
                                  && sent_count == (($past(sent_count) == 3'h4) ? 3'h4
                                                    : $past(sent_count) + 3'h1))
      else $error("checksum chain broken");

   rdata_idle_a : assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");

endmodule
`default_nettype wire

// ### src/hsc_cfg.svh
// address map, field codes, reset values and checksum constants of the hall sensor config block
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

// ------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ------------------------------------------------------------
`define HSC_OFF_DEV1       8'h00
`define HSC_OFF_DEV2       8'h01
`define HSC_OFF_SEN1       8'h02
`define HSC_OFF_SEN2       8'h03
`define HSC_OFF_STAT       8'h04
`define HSC_OFF_DATA       8'h10

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define HSC_RST_DEV1       8'h00
`define HSC_RST_DEV2       8'h00
`define HSC_RST_SEN1       8'h00
`define HSC_RST_SEN2       8'h00
`define HSC_RST_BYTE       8'h00

// ------------------------------------------------------------
// field codes
// ------------------------------------------------------------
`define HSC_OP_STANDBY     2'h0
`define HSC_TRIG_BUS       2'h0
`define HSC_CH_XY          4'h3
`define HSC_XY_WIDE        1'h1
`define HSC_ANGLE_XY       2'h1
`define HSC_CRC_ON         1'h1
`define HSC_FMT_STD        2'h0

// ------------------------------------------------------------
// full scale in mT: 40 / 80 low variant, 120 / 240 high variant
// ------------------------------------------------------------
`define HSC_FS_LO_NARROW   8'h28
`define HSC_FS_LO_WIDE     8'h50
`define HSC_FS_HI_NARROW   8'h78
`define HSC_FS_HI_WIDE     8'hF0

// ------------------------------------------------------------
// checksum: x^8+x^2+x+1, seeded with all ones, after four bytes
// ------------------------------------------------------------
`define HSC_CRC_SEED       8'hFF
`define HSC_CRC_POLY       8'h07
`define HSC_DATA_BYTES     3'h4
`define HSC_LAST_DATA      3'h3

`endif

// ### src/hsc_pkg.sv
// types shared by the hall sensor config block
package hsc_pkg;

   // ------------------------------------------------------------
   // register layouts
   // ------------------------------------------------------------
   typedef struct packed {
      logic [4:0] spare;
      logic [1:0] read_format;
      logic       crc_en;
   } hsc_dev1_type;

   typedef struct packed {
      logic [3:0] spare;
      logic [1:0] trigger_source;
      logic [1:0] operating_state_select;
   } hsc_dev2_type;

   typedef struct packed {
      logic [3:0] spare;
      logic [3:0] axis_channel_select;
   } hsc_sen1_type;

   typedef struct packed {
      logic [3:0] spare;
      logic [1:0] angle_select;
      logic       z_range;
      logic       xy_range;
   } hsc_sen2_type;

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   typedef struct packed {
      logic       standby;
      logic       bus_trigger;
      logic       x_en;
      logic       y_en;
      logic [7:0] xy_full_scale_mt;
      logic       z_range;
      logic       angle_en;
   } hsc_cfg_type;

   typedef struct packed {
      logic       valid;
      logic       is_crc;
      logic [7:0] data;
   } hsc_byte_type;

   typedef enum logic [1:0] {
      HSC_IDLE  = 2'b00,
      HSC_DATA  = 2'b01,
      HSC_CHECK = 2'b10
   } hsc_state_type;

endpackage

// ### src/hsc_crc_step.sv
// one byte step of the read checksum
`timescale 1ns/1ps
`default_nettype none
`include "hsc_cfg.svh"

module hsc_crc_step (
   input  wire logic [7:0] crc_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] crc_out
);

   // msb-first shift of crc xor data, eight bits folded in one cycle
   always_comb begin
      logic [7:0] acc;
      acc = crc_in ^ data_in;
      for (int i = 0; i < 8; i++) begin
         acc = acc[7] ? ((acc << 1) ^ `HSC_CRC_POLY) : (acc << 1);
      end
      crc_out = acc;
   end

endmodule
`default_nettype wire

// ### testbench/hsc_host_model.sv
// far-side host model that issues read frames on the stream port
`timescale 1ns/1ps
`default_nettype none

module hsc_host_model (
   input  wire logic       clock,
   output logic            stream_start,
   output logic      [7:0] stream_addr,
   output logic            stream_pop
);
   // ------------------------------------------------------------
   // idle levels
   // ------------------------------------------------------------
   initial begin
      stream_start = 1'b0;
      stream_addr  = 8'h00;
      stream_pop   = 1'b0;
   end

   // ------------------------------------------------------------
   // one read frame
   // ------------------------------------------------------------
   // start, then n pops; gap idle cycles between pops, zero holds pop high.
   // the address is inverted once taken so a late sample shows up as bad data
   task automatic frame(input logic [7:0] a, input int n, input int gap);
      @(posedge clock);
      stream_start <= 1'b1;
      stream_addr  <= a;
      @(posedge clock);
      stream_start <= 1'b0;
      stream_addr  <= ~a;
      for (int i = 0; i < n; i++) begin
         stream_pop <= 1'b1;
         @(posedge clock);
         if (gap > 0) begin
            stream_pop <= 1'b0;
            repeat (gap) @(posedge clock);
         end
      end
      stream_pop <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### testbench/hsc_config_crc_bench.sv
// self-checking bench of the hall sensor config decode and checksummed read stream
`timescale 1ns/1ps
`default_nettype none

module hsc_config_crc_bench;
   logic                  clock;
   logic                  sys_rst;
   logic [7:0]            reg_addr;
   logic [7:0]            reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [7:0]            reg_rdata;
   logic [7:0]            rdata_hi;
   logic                  stream_start;
   logic [7:0]            stream_addr;
   logic                  stream_pop;
   hsc_pkg::hsc_byte_type stream_out;
   hsc_pkg::hsc_byte_type stream_hi;
   hsc_pkg::hsc_cfg_type  cfg_out;
   hsc_pkg::hsc_cfg_type  cfg_hi;
   logic [7:0]            mem [16];
   logic [8:0]            byte_q [$];
   logic [7:0]            rd_q [$];
   logic                  rd_seen = 1'b0;
   logic [7:0]            rd_note;
   logic [8:0]            byte_note;
   int                    n_fail;
   int                    compares;

   // ------------------------------------------------------------
   // low and high range variants share every input
   // ------------------------------------------------------------
   hsc_config_crc #(.HIGH_RANGE(1'b0), .DATA_DEPTH(16)) i_dut (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stream_start(stream_start),
      .stream_addr(stream_addr), .stream_pop(stream_pop), .stream_out(stream_out), .cfg_out(cfg_out)
   );
   hsc_config_crc #(.HIGH_RANGE(1'b1), .DATA_DEPTH(16)) i_dut_hi (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_hi), .stream_start(stream_start),
      .stream_addr(stream_addr), .stream_pop(stream_pop), .stream_out(stream_hi), .cfg_out(cfg_hi)
   );
   hsc_host_model i_host (
      .clock(clock), .stream_start(stream_start), .stream_addr(stream_addr), .stream_pop(stream_pop)
   );

   // ------------------------------------------------------------
   // clock, compare and checksum helpers
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   // msb first, one byte per call
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
      return r;
   endfunction

   // ------------------------------------------------------------
   // output watcher: oldest note against each result
   // ------------------------------------------------------------
   // read data stand only in the cycle after the strobe, so look exactly there
   always @(posedge clock) begin
      if (rd_seen) begin
         if (rd_q.size() == 0) check("reg_rdata note", 16'h0001, 16'h0000);
         else begin
            rd_note = rd_q.pop_front();
            check("reg_rdata", {8'h00, rd_note}, {8'h00, reg_rdata});
            check("rdata_hi", {8'h00, rd_note}, {8'h00, rdata_hi});
         end
      end
      // both variants must stream the same bytes; range only changes the decode
      if (stream_out.valid === 1'b1 || stream_hi.valid === 1'b1) begin
         if (byte_q.size() == 0) check("stray byte", 16'h0000, 16'h0001);
         else begin
            byte_note = byte_q.pop_front();
            check("stream byte", {6'h00, 1'b1, byte_note}, {6'h00, stream_out});
            check("stream_hi", {6'h00, 1'b1, byte_note}, {6'h00, stream_hi});
         end
      end
      rd_seen <= reg_rd;
   end

   // ------------------------------------------------------------
   // register port and stream tasks
   // ------------------------------------------------------------
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
   endtask

   // flags: standby, bus_trigger, x_en, y_en, z_range, angle_en
   task automatic check_cfg(input logic [7:0] fs_lo, input logic [7:0] fs_hi, input logic [5:0] f);
      repeat (2) @(posedge clock);
      #1;
      check("cfg_out", {2'b00, f[5:2], fs_lo, f[1:0]}, {2'b00, cfg_out});
      check("cfg_hi", {2'b00, f[5:2], fs_hi, f[1:0]}, {2'b00, cfg_hi});
   endtask

   // bounded wait until every noted byte came out, then a few quiet cycles
   task automatic drain;
      int k;
      k = 0;
      while (byte_q.size() != 0 && k < 100) begin
         @(posedge clock);
         k++;
      end
      if (byte_q.size() != 0) begin
         n_fail++;
         $display("wrong value stream drain expected 0 seen %0d", byte_q.size());
         tally_and_finish();
      end
      repeat (3) @(posedge clock);
   endtask

   task automatic run_frame(input logic [7:0] a, input int n, input int gap, input bit crc);
      logic [7:0] c;
      logic [7:0] d;
      c = 8'hFF;
      for (int i = 0; i < n; i++) begin
         d = mem[(a + i) % 16];
         if (crc && i == 4) byte_q.push_back({1'b1, c});
         else if (!crc || i < 4) begin
            byte_q.push_back({1'b0, d});
            c = crc_step(c, d);
         end
      end
      i_host.frame(a, n, gap);
      drain();
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst   = 1'b1;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      n_fail    = 0;
      compares  = 0;
      void'($urandom(32'h093123c1));
      check("crc reference", 16'h0022, {8'h00, crc_step(8'hFF, 8'h2B)});
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      check_cfg(8'h28, 8'h78, 6'b110000);
      for (int a = 0; a < 4; a++) reg_read(8'(a), 8'h00);
      reg_write(8'h04, 8'hFF);
      reg_read(8'h04, 8'h01);
      reg_read(8'h20, 8'h00);
      $display("test 1 reset state done");
      for (int code = 0; code < 16; code++) begin
         reg_write(8'h02, 8'(code));
         check_cfg(8'h28, 8'h78, {2'b11, {2{code == 3}}, 2'b00});
      end
      reg_write(8'h02, 8'h03);
      reg_write(8'h03, 8'h05);
      check_cfg(8'h50, 8'hF0, 6'b111101);
      reg_write(8'h03, 8'h02);
      check_cfg(8'h28, 8'h78, 6'b111110);
      reg_write(8'h01, 8'h01);
      check_cfg(8'h28, 8'h78, 6'b011110);
      reg_write(8'h01, 8'h04);
      check_cfg(8'h28, 8'h78, 6'b101110);
      reg_read(8'h03, 8'h02);
      reg_read(8'h01, 8'h04);
      $display("test 2 config decode done");
      for (int a = 0; a < 16; a++) begin
         mem[a] = 8'($urandom());
         reg_write(8'h10 + 8'(a), mem[a]);
      end
      reg_read(8'h1F, mem[15]);
      reg_write(8'h00, 8'h01);
      run_frame(8'h10, 6, 0, 1'b1);
      $display("test 3 checksummed frame done");
      run_frame(8'h12, 5, 2, 1'b1);
      $display("test 4 slow frame done");
      run_frame(8'h14, 2, 0, 1'b1);
      run_frame(8'h10, 5, 0, 1'b1);
      $display("test 5 restart done");
      reg_write(8'h00, 8'h00);
      run_frame(8'h18, 6, 1, 1'b0);
      $display("test 6 checksum off done");
      reg_write(8'h00, 8'h03);
      run_frame(8'h10, 5, 0, 1'b0);
      $display("test 7 other format done");
      repeat (4) @(posedge clock);
      tally_and_finish();
   end
endmodule
`default_nettype wire
